/* File: design/capcmp_pkg.sv */
// Purpose: Shared constants and state types for the dual capture/compare unit.
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one register per word.
// Notes: Mode codes follow the channel mode field encoding.
package capcmp_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CHAN1_VALUE_LOW = 6'h00;
  localparam logic [5:0] OFS_CHAN1_VALUE_HIGH = 6'h04;
  localparam logic [5:0] OFS_CHAN2_VALUE_LOW = 6'h08;
  localparam logic [5:0] OFS_CHAN2_VALUE_HIGH = 6'h0C;
  localparam logic [5:0] OFS_CHAN1_CONTROL = 6'h10;
  localparam logic [5:0] OFS_CHAN2_CONTROL = 6'h14;
  localparam logic [5:0] OFS_THIRD_TIMER_CONTROL = 6'h18;
  localparam logic [5:0] OFS_EVENT_FLAGS = 6'h1C;
  localparam logic [5:0] OFS_PORT_DATA = 6'h20;
  localparam logic [5:0] OFS_PORT_DIRECTION = 6'h24;
  localparam logic [5:0] OFS_PIN_STATUS = 6'h28;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTL_W = 6;
  localparam int SEL1_BIT = 3;
  localparam int SEL2_BIT = 6;
  localparam logic [7:0] RST_THIRD_TIMER_CONTROL = 8'h00;
  localparam logic [5:0] RST_CONTROL = 6'h00;
  localparam logic [15:0] RST_VALUE = 16'h0000;
  localparam logic [1:0] RST_PORT_DIRECTION = 2'h3;
  localparam logic [1:0] RST_PORT_DATA = 2'h0;

  // ****************************************
  // Channel modes and prescaler counts
  // ****************************************
  typedef enum logic [3:0] {
    MODE_OFF = 4'b0000,
    MODE_CMP_TOGGLE = 4'b0010,
    MODE_CAP_FALL = 4'b0100,
    MODE_CAP_RISE = 4'b0101,
    MODE_CAP_RISE4 = 4'b0110,
    MODE_CAP_RISE16 = 4'b0111,
    MODE_CMP_SET_HIGH = 4'b1000,
    MODE_CMP_SET_LOW = 4'b1001,
    MODE_CMP_SOFT = 4'b1010,
    MODE_CMP_SPECIAL = 4'b1011
  } chan_mode_t;
  localparam logic [3:0] PRESC4_LAST = 4'h3;
  localparam logic [3:0] PRESC16_LAST = 4'hF;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [3:0] presc;
    logic latch;
    logic [3:0] mode_prev;
    logic match_prev;
  } chan_state_t;

  typedef struct packed {
    logic [15:0] val1;
    logic [15:0] val2;
    logic [5:0] ctl1;
    logic [5:0] ctl2;
    logic [7:0] t3ctl;
    logic [1:0] flags;
    logic [1:0] port_data;
    logic [1:0] port_dir;
    logic ack;
    logic [31:0] rdata;
    logic clr1;
    logic clr3;
    logic adc;
    logic [1:0] pin;
  } top_state_t;

endpackage

/* File: design/chan_if.sv */
// Purpose: Carries one channel's control, time base and events.
// Assumes: Driven by the unit top, answered by one channel instance.
// Notes: Strobes are one-cycle pulses.
`timescale 1ns/10ps
interface chan_if;
  logic [3:0] mode;
  logic [15:0] value;
  logic [15:0] timer;
  logic pin;
  logic capture_stb;
  logic match_stb;
  logic trigger_stb;
  logic out_latch;
  modport unit(input mode, input value, input timer, input pin,
    output capture_stb, output match_stb, output trigger_stb, output out_latch);
  modport ctrl(output mode, output value, output timer, output pin,
    input capture_stb, input match_stb, input trigger_stb, input out_latch);
endinterface

/* File: design/capcmp_channel.sv */
// Purpose: One capture/compare channel: edge capture with prescaler, compare output.
// Assumes: Pin synchronous to clk_in on paper; still double-registered.
// Notes: Value storage lives in the top; this module makes events and the compare output latch.
`timescale 1ns/10ps
module capcmp_channel (
  input wire logic clk_in,
  input wire logic rst_n_in,
  chan_if.unit ifc
);
  import capcmp_pkg::*;

  chan_state_t s_reg, s_next;
  logic rise, fall, is_cap, is_cmp, eq, match, cap;

  // ****************************************
  // Event logic
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.sync1 = ifc.pin;
    s_next.sync2 = s_reg.sync1;
    s_next.prev = s_reg.sync2;
    s_next.mode_prev = ifc.mode;
    rise = s_reg.sync2 & ~s_reg.prev;
    fall = ~s_reg.sync2 & s_reg.prev;
    is_cap = (ifc.mode[3:2] == 2'b01);
    is_cmp = (ifc.mode == MODE_CMP_TOGGLE) || (ifc.mode[3:2] == 2'b10);
    // PWM codes 11xx act as neither here; both share the second timer outside
    case (ifc.mode)
      MODE_CAP_FALL: cap = fall;
      MODE_CAP_RISE: cap = rise;
      MODE_CAP_RISE4: cap = rise && (s_reg.presc == PRESC4_LAST);
      MODE_CAP_RISE16: cap = rise && (s_reg.presc == PRESC16_LAST);
      default: cap = 1'b0;
    endcase
    // Prescaler survives capture-to-capture switches, so a first capture may come early
    if (!is_cap) begin
      s_next.presc = 4'h0;
    end else if (cap) begin
      s_next.presc = 4'h0;
    end else if (rise) begin
      s_next.presc = s_reg.presc + 4'h1;
    end
    // Equality edge only, so a stalled timer does not refire every cycle
    eq = (ifc.value == ifc.timer);
    match = is_cmp && eq && !s_reg.match_prev;
    s_next.match_prev = is_cmp && eq;
    if (ifc.mode == MODE_OFF) begin
      s_next.latch = 1'b0;
    end else if (ifc.mode != s_reg.mode_prev && ifc.mode == MODE_CMP_SET_HIGH) begin
      s_next.latch = 1'b0;
    end else if (ifc.mode != s_reg.mode_prev && ifc.mode == MODE_CMP_SET_LOW) begin
      s_next.latch = 1'b1;
    end else if (match) begin
      case (ifc.mode)
        MODE_CMP_TOGGLE: s_next.latch = ~s_reg.latch;
        MODE_CMP_SET_HIGH: s_next.latch = 1'b1;
        MODE_CMP_SET_LOW: s_next.latch = 1'b0;
        default: s_next.latch = s_reg.latch;
      endcase
    end
    ifc.capture_stb = cap;
    ifc.match_stb = match;
    ifc.trigger_stb = match && (ifc.mode == MODE_CMP_SPECIAL);
    ifc.out_latch = s_reg.latch;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_rise_capture: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($rose(ifc.pin) && ifc.mode == MODE_CAP_RISE) ##1
    (ifc.pin && ifc.mode == MODE_CAP_RISE)[*2] |-> ifc.capture_stb)
    else $error("rising edge not captured");
  a_off_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ifc.mode == MODE_OFF) |=> (s_reg.presc == 4'h0 && !ifc.out_latch))
    else $error("off mode did not clear state");
  a_fourth_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ifc.capture_stb && ifc.mode == MODE_CAP_RISE4) |->
    (s_reg.presc == 4'h3) ##1 (s_reg.presc == 4'h0))
    else $error("divide by four capture at wrong count");
  a_toggle_match: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ifc.match_stb && ifc.mode == MODE_CMP_TOGGLE) |=> (ifc.out_latch != $past(ifc.out_latch)))
    else $error("toggle on match missing");
  a_soft_untouched: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ifc.match_stb && ifc.mode == MODE_CMP_SOFT && $past(ifc.mode) == MODE_CMP_SOFT)
    |=> $stable(ifc.out_latch))
    else $error("software compare moved the pin");
  a_trigger_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ifc.trigger_stb |-> (ifc.mode == MODE_CMP_SPECIAL && ifc.value == ifc.timer))
    else $error("special trigger without match");
endmodule

/* File: design/capcmp_top.sv */
// Purpose: Dual capture/compare unit with Avalon-MM register slave.
// Assumes: Timer counts arrive as inputs; timers and converter live outside.
// Notes: Each register access answers after one wait cycle.
//
// What this block does
// - Each channel value is a readable, writable low byte and high byte.
// - Each channel uses first or third timer, chosen in third timer control.
// - Capture copies the full 16-bit selected timer count into the value.
// - Capture on falling, rising, every fourth or sixteenth rising edge.
// - Each capture sets the channel flag; only software clears it.
// - New capture overwrites the value register, with no overrun flag.
// - Edge detection watches the pin level whatever the pin direction.
// - Prescaler is cleared when off, outside capture modes, and by reset.
// - Switching capture prescaler settings directly leaves the count uncleared.
// - Compare mode checks value against selected timer continuously for equality.
// - Match drives high, low, toggles or leaves pin, and sets flag.
// - Control zero forces the compare output latch low, apart from port latch.
// - Software compare mode only sets the flag, pin untouched.
// - First channel special trigger clears its timer, acting as period.
// - Either trigger clears its timer; second also starts enabled conversion.
// - Second channel trigger sets no first or third timer overflow flag.
// - PWM codes 11xx do nothing here; PWM on both channels shares the second timer outside this block.
// - Capture codes 0100 fall, 0101 rise, 0110 fourth, 0111 sixteenth rise.
// - Compare codes 0010 toggle, 1000 low-then-high, 1001 high-then-low, 1010, 1011.
// - Mode 0000 turns the channel off and resets its state.
`timescale 1ns/10ps
module capcmp_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [capcmp_pkg::ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  input wire logic [15:0] first_timer_count_in,
  input wire logic [15:0] third_timer_count_in,
  output logic first_timer_clear_out,
  output logic third_timer_clear_out,
  input wire logic adc_enable_in,
  output logic adc_start_out,
  input wire logic chan1_pin_in,
  output logic chan1_pin_out,
  output logic chan1_pin_oe_out,
  input wire logic chan2_pin_in,
  output logic chan2_pin_out,
  output logic chan2_pin_oe_out,
  output logic chan1_event_flag_out,
  output logic chan2_event_flag_out
);
  import capcmp_pkg::*;

  top_state_t s_reg, s_next;
  chan_if ch1 ();
  chan_if ch2 ();
  logic sel1, sel2, req, take_wr;
  logic [1:0] flag_set, flag_clr;
  logic [15:0] first_timer_count, tmr2;
  logic [31:0] rd_mux;

  // ****************************************
  // Channels
  // ****************************************
  assign sel1 = s_reg.t3ctl[SEL1_BIT];
  assign sel2 = s_reg.t3ctl[SEL2_BIT];
  assign first_timer_count = sel1 ? third_timer_count_in : first_timer_count_in;
  assign tmr2 = sel2 ? third_timer_count_in : first_timer_count_in;
  assign ch1.mode = s_reg.ctl1[3:0];
  assign ch1.value = s_reg.val1;
  assign ch1.timer = first_timer_count;
  assign ch1.pin = chan1_pin_in;
  assign ch2.mode = s_reg.ctl2[3:0];
  assign ch2.value = s_reg.val2;
  assign ch2.timer = tmr2;
  assign ch2.pin = chan2_pin_in;

  capcmp_channel u_chan1 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ifc(ch1)
  );

  capcmp_channel u_chan2 (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ifc(ch2)
  );

  // ****************************************
  // Bus slave and register file
  // ****************************************
  // One wait state: data is fetched while waitrequest is high, presented after
  assign req = read_in | write_in;
  assign waitrequest_out = req & ~s_reg.ack;
  assign take_wr = s_reg.ack & write_in & byteenable_in[0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (address_in)
      OFS_CHAN1_VALUE_LOW: rd_mux[7:0] = s_reg.val1[7:0];
      OFS_CHAN1_VALUE_HIGH: rd_mux[7:0] = s_reg.val1[15:8];
      OFS_CHAN2_VALUE_LOW: rd_mux[7:0] = s_reg.val2[7:0];
      OFS_CHAN2_VALUE_HIGH: rd_mux[7:0] = s_reg.val2[15:8];
      OFS_CHAN1_CONTROL: rd_mux[5:0] = s_reg.ctl1;
      OFS_CHAN2_CONTROL: rd_mux[5:0] = s_reg.ctl2;
      OFS_THIRD_TIMER_CONTROL: rd_mux[7:0] = s_reg.t3ctl;
      OFS_EVENT_FLAGS: rd_mux[1:0] = s_reg.flags;
      OFS_PORT_DATA: rd_mux[1:0] = s_reg.port_data;
      OFS_PORT_DIRECTION: rd_mux[1:0] = s_reg.port_dir;
      OFS_PIN_STATUS: rd_mux[3:0] = {chan2_pin_in, chan1_pin_in, ch2.out_latch, ch1.out_latch};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    s_next.ack = req & ~s_reg.ack;
    if (req && !s_reg.ack) begin
      s_next.rdata = rd_mux;
    end
    flag_set = {ch2.capture_stb | ch2.match_stb, ch1.capture_stb | ch1.match_stb};
    flag_clr = 2'b00;
    if (take_wr) begin
      case (address_in)
        OFS_CHAN1_VALUE_LOW: s_next.val1[7:0] = writedata_in[7:0];
        OFS_CHAN1_VALUE_HIGH: s_next.val1[15:8] = writedata_in[7:0];
        OFS_CHAN2_VALUE_LOW: s_next.val2[7:0] = writedata_in[7:0];
        OFS_CHAN2_VALUE_HIGH: s_next.val2[15:8] = writedata_in[7:0];
        OFS_CHAN1_CONTROL: s_next.ctl1 = writedata_in[CTL_W-1:0];
        OFS_CHAN2_CONTROL: s_next.ctl2 = writedata_in[CTL_W-1:0];
        OFS_THIRD_TIMER_CONTROL: s_next.t3ctl = writedata_in[7:0];
        OFS_EVENT_FLAGS: flag_clr = writedata_in[1:0];
        OFS_PORT_DATA: s_next.port_data = writedata_in[1:0];
        OFS_PORT_DIRECTION: s_next.port_dir = writedata_in[1:0];
        default: s_next.rdata = s_reg.rdata;
      endcase
    end
    // Capture beats a same-cycle software write; no overrun is recorded
    if (ch1.capture_stb) begin
      s_next.val1 = first_timer_count;
    end
    if (ch2.capture_stb) begin
      s_next.val2 = tmr2;
    end
    s_next.flags = (s_reg.flags & ~flag_clr) | flag_set;
    // Clears go only to the timer in use; no overflow flag is touched here
    s_next.clr1 = (ch1.trigger_stb & ~sel1) | (ch2.trigger_stb & ~sel2);
    s_next.clr3 = (ch1.trigger_stb & sel1) | (ch2.trigger_stb & sel2);
    s_next.adc = ch2.trigger_stb & adc_enable_in;
    // Compare latch owns the pin in compare modes, port latch otherwise
    s_next.pin[0] = (ch1.mode == MODE_CMP_TOGGLE || ch1.mode[3:2] == 2'b10) ?
      ch1.out_latch : s_reg.port_data[0];
    s_next.pin[1] = (ch2.mode == MODE_CMP_TOGGLE || ch2.mode[3:2] == 2'b10) ?
      ch2.out_latch : s_reg.port_data[1];
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg <= '0;
      s_reg.val1 <= RST_VALUE;
      s_reg.val2 <= RST_VALUE;
      s_reg.ctl1 <= RST_CONTROL;
      s_reg.ctl2 <= RST_CONTROL;
      s_reg.t3ctl <= RST_THIRD_TIMER_CONTROL;
      s_reg.port_data <= RST_PORT_DATA;
      s_reg.port_dir <= RST_PORT_DIRECTION;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign readdata_out = s_reg.rdata;
  assign first_timer_clear_out = s_reg.clr1;
  assign third_timer_clear_out = s_reg.clr3;
  assign adc_start_out = s_reg.adc;
  assign chan1_pin_out = s_reg.pin[0];
  assign chan2_pin_out = s_reg.pin[1];
  // Direction bit set means input, as software is expected to choose in capture
  assign chan1_pin_oe_out = ~s_reg.port_dir[0];
  assign chan2_pin_oe_out = ~s_reg.port_dir[1];
  assign chan1_event_flag_out = s_reg.flags[0];
  assign chan2_event_flag_out = s_reg.flags[1];

  // ****************************************
  // Checks
  // ****************************************
  a_bus_answer: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (req && waitrequest_out) |=> !waitrequest_out)
    else $error("bus request not answered in one wait cycle");
  a_flag_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ch1.capture_stb || ch1.match_stb) |=> chan1_event_flag_out)
    else $error("channel one flag not set by event");
  a_capture_store: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ch2.capture_stb |=> (s_reg.val2 == $past(tmr2)))
    else $error("captured value does not match timer");
  a_period_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ch1.trigger_stb && !sel1) |=> first_timer_clear_out)
    else $error("first timer not cleared by trigger");
  a_adc_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    adc_start_out |-> $past(ch2.trigger_stb && adc_enable_in))
    else $error("conversion start without enabled trigger");
endmodule

/* File: test/pin_source.sv */
// Purpose: External digital signal on one capture/compare pin.
// Assumes: The bench sets the source level just after a rising clock edge.
// Notes: The device's own drive wins while its output enable is high.
`timescale 1ns/10ps
module pin_source (
  input wire logic level_in,
  input wire logic dev_out_in,
  input wire logic dev_oe_in,
  output logic wire_out
);
  // ****************************************
  // Wire resolution
  // ****************************************
  // Source only reaches the wire while the pin is an input
  assign wire_out = dev_oe_in ? dev_out_in : level_in;
endmodule

/* File: test/dual_capture_compare_unit_test.sv */
// Purpose: Self-checking bench for the dual capture/compare unit.
// Assumes: Timer counts and pin levels are held by the bench between events.
// Notes: Random values come from one fixed seed.
`timescale 1ns/10ps
module dual_capture_compare_unit_test;
  import capcmp_pkg::*;
  logic clk_in, rst_n_in, read_in, write_in, waitrequest_out, adc_en;
  logic clr1, clr3, adc_start, sel;
  logic [5:0] address_in;
  logic [31:0] writedata_in, readdata_out, rd;
  logic [3:0] be;
  logic [15:0] t1, t3, a, b, e, v;
  logic [1:0] ext;
  // Nets, since each bit has its own driver
  wire logic [1:0] pin, pout, poe, flag;
  int n_fail, n_compared, n_clr1, n_clr3, n_adc, c1, c3, cadc, n;
  chan_mode_t cmp_modes[5] = '{MODE_CMP_SET_HIGH, MODE_CMP_SET_LOW, MODE_CMP_TOGGLE,
    MODE_CMP_SOFT, MODE_CMP_SPECIAL};

  capcmp_top u_capcmp_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(be),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .first_timer_count_in(t1), .third_timer_count_in(t3), .first_timer_clear_out(clr1),
    .third_timer_clear_out(clr3), .adc_enable_in(adc_en), .adc_start_out(adc_start),
    .chan1_pin_in(pin[0]), .chan1_pin_out(pout[0]), .chan1_pin_oe_out(poe[0]),
    .chan2_pin_in(pin[1]), .chan2_pin_out(pout[1]), .chan2_pin_oe_out(poe[1]),
    .chan1_event_flag_out(flag[0]), .chan2_event_flag_out(flag[1]));
  pin_source u_pin_source_1 (.level_in(ext[0]), .dev_out_in(pout[0]), .dev_oe_in(poe[0]),
    .wire_out(pin[0]));
  pin_source u_pin_source_2 (.level_in(ext[1]), .dev_out_in(pout[1]), .dev_oe_in(poe[1]),
    .wire_out(pin[1]));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Pulse counters, so one-cycle strobes are never missed
  always @(posedge clk_in) begin
    if (clr1 === 1'b1) n_clr1++;
    if (clr3 === 1'b1) n_clr3++;
    if (adc_start === 1'b1) n_adc++;
  end

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] d);
    @(posedge clk_in);
    address_in <= adr;
    writedata_in <= d;
    read_in <= !wr;
    write_in <= wr;
    @(posedge clk_in);
    while (waitrequest_out !== 1'b0) @(posedge clk_in);
    rd = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
  endtask

  task automatic rdchk(input logic [5:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask

  function automatic logic [5:0] vlo(input int ch);
    return ch ? OFS_CHAN2_VALUE_LOW : OFS_CHAN1_VALUE_LOW;
  endfunction

  task automatic ctl(input int ch, input logic [3:0] m);
    bus(1'b1, ch ? OFS_CHAN2_CONTROL : OFS_CHAN1_CONTROL, 32'(m));
  endtask

  task automatic clr_flags();
    bus(1'b1, OFS_EVENT_FLAGS, 32'h3);
  endtask

  // Counts change on the clock edge, as a synchronous timer would
  task automatic set_t(input logic [15:0] x, input logic [15:0] y);
    @(posedge clk_in);
    t1 <= x;
    t3 <= y;
  endtask

  // Level held long enough to pass the synchroniser and edge detect
  task automatic set_pin(input int ch, input logic lvl);
    @(posedge clk_in);
    ext[ch] <= lvl;
    repeat (5) @(posedge clk_in);
  endtask

  task automatic pulses(input int ch, input int cnt);
    repeat (cnt) begin
      set_pin(ch, 1'b1);
      set_pin(ch, 1'b0);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    report_and_stop();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n_in = 1'b0;
    read_in = 1'b0;
    write_in = 1'b0;
    address_in = 6'h00;
    writedata_in = 32'h0;
    be = 4'hF;
    t1 = 16'h0;
    t3 = 16'h0;
    ext = 2'h0;
    adc_en = 1'b0;
    void'($urandom(32'h9FB6));
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      rdchk(6'(i * 4), (6'(i * 4) == OFS_PORT_DIRECTION) ? 32'h3 : 32'h0);
    end
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      bus(1'b1, 6'(i * 4), {24'h0, v[7:0]});
      be <= 4'h0;
      bus(1'b1, 6'(i * 4), {24'h0, ~v[7:0]});
      be <= 4'hF;
      rdchk(6'(i * 4), {24'h0, v[7:0]});
    end
    bus(1'b1, 6'h3C, 32'hFF);
    rdchk(6'h3C, 32'h0);
    $display("test value registers done");
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 2; k++) begin
        sel = 1'($urandom);
        a = 16'($urandom);
        b = 16'($urandom);
        e = sel ? b : a;
        bus(1'b1, OFS_THIRD_TIMER_CONTROL, 32'(sel) << (ch ? SEL2_BIT : SEL1_BIT));
        set_t(a, b);
        ctl(ch, 4'h0);
        ctl(ch, k ? MODE_CAP_RISE : MODE_CAP_FALL);
        clr_flags();
        set_pin(ch, 1'b1);
        chk(32'(flag[ch]), 32'(k));
        set_pin(ch, 1'b0);
        chk(32'(flag[ch]), 32'h1);
        rdchk(vlo(ch), 32'(e[7:0]));
        rdchk(vlo(ch) + 6'h4, 32'(e[15:8]));
        set_t(~a, ~b);
        pulses(ch, 1);
        chk(32'(flag[ch]), 32'h1);
        rdchk(vlo(ch), {24'h0, ~e[7:0]});
      end
    end
    $display("test capture edges done");
    for (int k = 0; k < 2; k++) begin
      n = k ? 16 : 4;
      ctl(0, k ? MODE_CAP_RISE16 : MODE_CAP_RISE4);
      pulses(0, 2);
      ctl(0, 4'h0);
      ctl(0, k ? MODE_CAP_RISE16 : MODE_CAP_RISE4);
      clr_flags();
      pulses(0, n - 1);
      chk(32'(flag[0]), 32'h0);
      pulses(0, 1);
      chk(32'(flag[0]), 32'h1);
    end
    $display("test prescaler done");
    ctl(0, MODE_CAP_RISE);
    bus(1'b1, OFS_PORT_DIRECTION, 32'h2);
    clr_flags();
    chk(32'(poe), 32'h1);
    bus(1'b1, OFS_PORT_DATA, 32'h1);
    repeat (6) @(posedge clk_in);
    chk(32'(flag[0]), 32'h1);
    bus(1'b1, OFS_PORT_DATA, 32'h0);
    $display("test port write capture done");
    bus(1'b1, OFS_PORT_DIRECTION, 32'h0);
    @(posedge clk_in);
    chk(32'(poe), 32'h3);
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 5; k++) begin
        sel = 1'($urandom);
        v = 16'($urandom);
        @(posedge clk_in);
        adc_en <= 1'($urandom);
        bus(1'b1, OFS_THIRD_TIMER_CONTROL, 32'(sel) << (ch ? SEL2_BIT : SEL1_BIT));
        bus(1'b1, vlo(ch), 32'(v[7:0]));
        bus(1'b1, vlo(ch) + 6'h4, 32'(v[15:8]));
        set_t(v - 16'h1, v - 16'h1);
        ctl(ch, 4'h0);
        repeat (3) @(posedge clk_in);
        chk(32'(pout[ch]), 32'h0);
        bus(1'b0, OFS_PIN_STATUS, 32'h0);
        chk(32'(rd[ch]), 32'h0);
        ctl(ch, cmp_modes[k]);
        clr_flags();
        repeat (3) @(posedge clk_in);
        chk(32'(pout[ch]), 32'(k == 1));
        chk(32'(flag[ch]), 32'h0);
        c1 = n_clr1;
        c3 = n_clr3;
        cadc = n_adc;
        set_t(sel ? v - 16'h1 : v, sel ? v : v - 16'h1);
        repeat (4) @(posedge clk_in);
        chk(32'(flag[ch]), 32'h1);
        if (k != 4) chk(32'(pout[ch]), 32'(k == 0 || k == 2));
        chk(32'(n_clr1 - c1), 32'(k == 4 && !sel));
        chk(32'(n_clr3 - c3), 32'(k == 4 && sel));
        chk(32'(n_adc - cadc), 32'(k == 4 && ch == 1 && adc_en));
      end
      ctl(ch, 4'h0);
    end
    $display("test compare modes done");
    report_and_stop();
  end
endmodule
